// ==== include/changeover_pkg.sv ====
package changeover_pkg;

  localparam int          CLK_HZ            = 20_000_000;
  localparam int          SECOND_S          = 1;
  localparam int          CYCLES_PER_SECOND = SECOND_S * CLK_HZ;
  localparam int          TICK_W            = 25;

  localparam int          NUM_CH   = 12;
  localparam int          NUM_ERR  = 6;
  localparam int          NUM_PSU  = 2;
  localparam int          NUM_TEMP = 4;
  localparam int          IRQ_W    = 5;

  localparam logic [3:0]  NCH_MIN        = 4'h1;
  localparam logic [3:0]  NCH_MAX        = 4'hc;
  localparam logic [3:0]  NCH_RESET      = 4'hc;
  localparam logic [16:0] DELAY_MAX      = 17'h1517f;
  localparam logic [16:0] DELAY_RESET    = 17'h0001e;
  localparam logic [16:0] SEC_PER_HOUR   = 17'h00e10;
  localparam logic [16:0] SEC_PER_MIN    = 17'h0003c;
  localparam logic [11:0] HOUR_LAST_SEC  = 12'he0f;

  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  STATUS_OFS     = 8'h04;
  localparam logic [7:0]  DELAY_OFS      = 8'h08;
  localparam logic [7:0]  DELAY_HMS_OFS  = 8'h0c;
  localparam logic [7:0]  COUNTDOWN_OFS  = 8'h10;
  localparam logic [7:0]  IRQ_STAT_OFS   = 8'h14;
  localparam logic [7:0]  IRQ_MASK_OFS   = 8'h18;
  localparam logic [7:0]  PERR_BASE      = 8'h20;
  localparam logic [7:0]  BERR_BASE      = 8'h40;
  localparam logic [7:0]  PSU_BASE       = 8'h60;
  localparam logic [7:0]  TEMP_BASE      = 8'h70;

  localparam int          CTL_MANUAL     = 4;
  localparam int          CTL_MAN_BACKUP = 5;
  localparam int          CTL_REC_DELAY  = 6;
  localparam int          CTL_PSU_CLR    = 8;
  localparam int          CTL_TEMP_CLR   = 10;

  localparam int          IRQ_CHANGE     = 0;
  localparam int          IRQ_PFAULT     = 1;
  localparam int          IRQ_BFAULT     = 2;
  localparam int          IRQ_PSU        = 3;
  localparam int          IRQ_RECOVER    = 4;

  localparam int          SY_PF          = 0;
  localparam int          SY_BF          = 1;
  localparam int          SY_PSU         = 2;
  localparam int          SY_FIT         = 4;
  localparam int          SY_STB         = 8;
  localparam int          SY_TEMP        = 9;
  localparam int          SYNC_W         = 41;

  function automatic logic auto_select(input logic pf, input logic bf);
    logic backup;
    backup = 1'b0;
    case ({pf, bf})
      2'b00:   backup = 1'b0;
      2'b10:   backup = 1'b1;
      2'b01:   backup = 1'b0;
      2'b11:   backup = 1'b1;
      default: backup = 1'b0;
    endcase
    return backup;
  endfunction

  function automatic logic [16:0] clamp_delay(input logic [31:0] v);
    return (v > {15'h0000, DELAY_MAX}) ? DELAY_MAX : v[16:0];
  endfunction

endpackage

// ==== include/recover_if.sv ====
`timescale 1ns/100ps
interface recover_if;
  logic        tick;
  logic        start;
  logic        cancel;
  logic [16:0] delay_s;
  logic        active;
  logic        expire;
  logic [16:0] remaining;
  logic [4:0]  hh;
  logic [5:0]  mm;
  logic [5:0]  ss;
  modport ctrl (output tick, start, cancel, delay_s, input active, expire, remaining, hh, mm, ss);
  modport timer (input tick, start, cancel, delay_s, output active, expire, remaining, hh, mm, ss);
endinterface

// ==== core/recover_timer.sv ====
`timescale 1ns/100ps
module recover_timer
  import changeover_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  recover_if.timer  rif
);

  typedef struct packed {
    logic [16:0] cnt;
    logic        active;
    logic        expire;
    logic [4:0]  hh;
    logic [5:0]  mm;
    logic [5:0]  ss;
  } timer_state_type;

  timer_state_type t_reg;
  timer_state_type t_next;

  always_comb
  begin
    t_next = t_reg;
    t_next.expire = 1'b0;
    if (rif.cancel)
    begin
      t_next.active = 1'b0;
      t_next.cnt = 17'h00000;
    end
    else if (rif.start && !t_reg.active)
    begin
      t_next.cnt = rif.delay_s;
      t_next.active = (rif.delay_s != 17'h00000);
      t_next.expire = (rif.delay_s == 17'h00000);
    end
    else if (t_reg.active && rif.tick)
    begin
      if (t_reg.cnt <= 17'h00001)
      begin
        t_next.cnt = 17'h00000;
        t_next.active = 1'b0;
        t_next.expire = 1'b1;
      end
      else
      begin
        t_next.cnt = t_reg.cnt - 17'h00001;
      end
    end
    t_next.hh = 5'(rif.delay_s / SEC_PER_HOUR);
    t_next.mm = 6'((rif.delay_s % SEC_PER_HOUR) / SEC_PER_MIN);
    t_next.ss = 6'(rif.delay_s % SEC_PER_MIN);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  assign rif.active    = t_reg.active;
  assign rif.expire    = t_reg.expire;
  assign rif.remaining = t_reg.cnt;
  assign rif.hh        = t_reg.hh;
  assign rif.mm        = t_reg.mm;
  assign rif.ss        = t_reg.ss;

endmodule

// ==== core/redundant_source_changeover.sv ====
`timescale 1ns/100ps
// Overview of operation
// - Measuring channel count is settable from 1 to 12 and readable.
// - Changeover mode is automatic or manual, readable as status.
// - Auto: none or backup faulted picks primary, else backup.
// - Auto mode watches faults and defaults outputs to primary.
// - Auto mode returns to primary once its fault clears.
// - Manual mode ignores faults; outputs follow operator choice only.
// - Status shows whether primary or backup currently drives outputs.
// - Recovery delay in whole seconds, at most 86399, also shown as h:m:s.
// - Delayed recovery waits the programmed seconds before acting.
// - A countdown shows seconds left while recovery is pending.
// - Six most recent errors kept per source, first to sixth.
// - Each supply tracks status, turn-ons and hours; reset clears them.
// - Each fitted sensor reports current, lowest and highest reading.
// - An unfitted sensor is marked absent instead of giving readings.
// - All output channels switch source together on every changeover.
module redundant_source_changeover
  import changeover_pkg::*;
#(
  parameter int CYCLES_PER_SECOND_P = CYCLES_PER_SECOND
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              primary_fault,
  input  wire logic              backup_fault,
  input  wire logic [1:0]        psu_ok,
  input  wire logic [3:0]        temp_fitted,
  input  wire logic              temp_strobe,
  input  wire logic [3:0][7:0]   temp_data,
  output logic                   sel_backup,
  output logic      [NUM_CH-1:0] chan_backup,
  output logic                   irq
);

  typedef struct packed {
    logic [SYNC_W-1:0]          sy1;
    logic [SYNC_W-1:0]          sy2;
    logic                       pf_d;
    logic                       bf_d;
    logic [1:0]                 psu_d;
    logic                       stb_d;
    logic                       ph_wr;
    logic [7:0]                 ph_addr;
    logic [31:0]                hrdata;
    logic                       hready;
    logic                       hresp;
    logic [3:0]                 nch;
    logic                       manual;
    logic                       man_backup;
    logic                       rec_delayed;
    logic [16:0]                delay;
    logic                       sel_backup;
    logic [NUM_CH-1:0]          chan;
    logic [TICK_W-1:0]          tick_cnt;
    logic                       tick;
    logic [16:0]                uptime;
    logic                       start;
    logic                       cancel;
    logic [IRQ_W-1:0]           irq_stat;
    logic [IRQ_W-1:0]           irq_mask;
    logic                       irq;
    logic [NUM_ERR-1:0][16:0]   perr;
    logic [NUM_ERR-1:0][16:0]   berr;
    logic [NUM_PSU-1:0][15:0]   psu_cnt;
    logic [NUM_PSU-1:0][15:0]   psu_hours;
    logic [NUM_PSU-1:0][11:0]   psu_sec;
    logic [NUM_TEMP-1:0][7:0]   tcur;
    logic [NUM_TEMP-1:0][7:0]   tmin;
    logic [NUM_TEMP-1:0][7:0]   tmax;
    logic [NUM_TEMP-1:0]        tseen;
  } state_type;

  state_type s_reg;
  state_type s_next;

  recover_if rif ();

  recover_timer u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .rif     (rif.timer)
  );

  assign rif.tick    = s_reg.tick;
  assign rif.start   = s_reg.start;
  assign rif.cancel  = s_reg.cancel;
  assign rif.delay_s = s_reg.delay;

  always_comb
  begin
    logic [SYNC_W-1:0] sy;
    logic              pf;
    logic              bf;
    logic              want;
    logic              recovering;
    logic              new_sel;
    logic              addr_ok;
    logic [7:0]        ra;
    logic [31:0]       rd;
    logic [IRQ_W-1:0]  set;
    logic [IRQ_W-1:0]  clr;
    logic [1:0]        psu_clr;
    logic              temp_clr;
    logic              stb_rise;
    logic [7:0]        td;
    sy = s_reg.sy2;
    pf = sy[SY_PF];
    bf = sy[SY_BF];
    want = 1'b0;
    recovering = 1'b0;
    new_sel = s_reg.sel_backup;
    addr_ok = (haddr[31:8] == 24'h000000);
    ra = haddr[7:0];
    rd = 32'h00000000;
    set = '0;
    clr = '0;
    psu_clr = 2'b00;
    temp_clr = 1'b0;
    stb_rise = sy[SY_STB] && !s_reg.stb_d;
    td = 8'h00;

    s_next = s_reg;
    s_next.sy1 = {temp_data, temp_strobe, temp_fitted, psu_ok, backup_fault, primary_fault};
    s_next.sy2 = s_reg.sy1;
    s_next.pf_d = pf;
    s_next.bf_d = bf;
    s_next.psu_d = sy[SY_PSU+:2];
    s_next.stb_d = sy[SY_STB];
    s_next.start = 1'b0;
    s_next.cancel = 1'b0;

    // One-second tick and time-of-day stamp
    s_next.tick = 1'b0;
    if (s_reg.tick_cnt == TICK_W'(CYCLES_PER_SECOND_P - 1))
    begin
      s_next.tick_cnt = '0;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.tick_cnt = s_reg.tick_cnt + TICK_W'(1);
    end
    if (s_reg.tick)
      s_next.uptime = (s_reg.uptime == DELAY_MAX) ? 17'h00000 : s_reg.uptime + 17'h00001;

    // Register writes in the data phase
    if (s_reg.ph_wr)
    begin
      case (s_reg.ph_addr)
        CTRL_OFS:
        begin
          if (hwdata[3:0] >= NCH_MIN && hwdata[3:0] <= NCH_MAX)
            s_next.nch = hwdata[3:0];
          s_next.manual = hwdata[CTL_MANUAL];
          s_next.man_backup = hwdata[CTL_MAN_BACKUP];
          s_next.rec_delayed = hwdata[CTL_REC_DELAY];
          psu_clr = hwdata[CTL_PSU_CLR+:2];
          temp_clr = hwdata[CTL_TEMP_CLR];
        end
        DELAY_OFS:
          s_next.delay = clamp_delay(hwdata);
        IRQ_STAT_OFS:
          clr = hwdata[IRQ_W-1:0];
        IRQ_MASK_OFS:
          s_next.irq_mask = hwdata[IRQ_W-1:0];
        default:
          clr = '0;
      endcase
    end

    // Source selection
    if (s_reg.manual)
    begin
      new_sel = s_reg.man_backup;
      s_next.cancel = rif.active;
    end
    else
    begin
      want = auto_select(pf, bf);
      recovering = s_reg.sel_backup && !pf && !bf;
      if (recovering && s_reg.rec_delayed)
      begin
        s_next.start = !rif.active && !s_reg.start;
        if (rif.expire)
        begin
          new_sel = 1'b0;
          set[IRQ_RECOVER] = 1'b1;
        end
      end
      else
      begin
        new_sel = want;
        s_next.cancel = rif.active;
        if (recovering)
          set[IRQ_RECOVER] = 1'b1;
      end
    end
    s_next.sel_backup = new_sel;
    s_next.chan = {NUM_CH{new_sel}};
    set[IRQ_CHANGE] = (new_sel != s_reg.sel_backup);

    // Error histories, newest in the first slot
    if (pf && !s_reg.pf_d)
    begin
      s_next.perr = {s_reg.perr[NUM_ERR-2:0], s_reg.uptime};
      set[IRQ_PFAULT] = 1'b1;
    end
    if (bf && !s_reg.bf_d)
    begin
      s_next.berr = {s_reg.berr[NUM_ERR-2:0], s_reg.uptime};
      set[IRQ_BFAULT] = 1'b1;
    end

    // Supply counters
    for (int p = 0; p < NUM_PSU; p++)
    begin
      if (psu_clr[p])
      begin
        s_next.psu_cnt[p] = 16'h0000;
        s_next.psu_hours[p] = 16'h0000;
        s_next.psu_sec[p] = 12'h000;
      end
      else
      begin
        if (sy[SY_PSU+p] && !s_reg.psu_d[p])
          s_next.psu_cnt[p] = s_reg.psu_cnt[p] + 16'h0001;
        if (sy[SY_PSU+p] && s_reg.tick)
        begin
          if (s_reg.psu_sec[p] == HOUR_LAST_SEC)
          begin
            s_next.psu_sec[p] = 12'h000;
            s_next.psu_hours[p] = s_reg.psu_hours[p] + 16'h0001;
          end
          else
          begin
            s_next.psu_sec[p] = s_reg.psu_sec[p] + 12'h001;
          end
        end
      end
      if (!sy[SY_PSU+p] && s_reg.psu_d[p])
        set[IRQ_PSU] = 1'b1;
    end

    // Temperature tracking
    for (int t = 0; t < NUM_TEMP; t++)
    begin
      td = sy[SY_TEMP+8*t+:8];
      if (!sy[SY_FIT+t] || temp_clr)
      begin
        s_next.tseen[t] = 1'b0;
      end
      else if (stb_rise)
      begin
        s_next.tcur[t] = td;
        s_next.tseen[t] = 1'b1;
        if (!s_reg.tseen[t] || $signed(td) < $signed(s_reg.tmin[t]))
          s_next.tmin[t] = td;
        if (!s_reg.tseen[t] || $signed(td) > $signed(s_reg.tmax[t]))
          s_next.tmax[t] = td;
      end
    end

    // Interrupt status, a new event beats a clear
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | set;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

    // Read mux, sampled in the address phase
    case (ra)
      CTRL_OFS:
        rd = {25'h0000000, s_reg.rec_delayed, s_reg.man_backup, s_reg.manual, s_reg.nch};
      STATUS_OFS:
        rd = {20'h00000, s_reg.psu_d, rif.active, bf, pf, s_reg.rec_delayed,
              s_reg.sel_backup, s_reg.manual, s_reg.nch};
      DELAY_OFS:
        rd = {15'h0000, s_reg.delay};
      DELAY_HMS_OFS:
        rd = {11'h000, rif.hh, 2'b00, rif.mm, 2'b00, rif.ss};
      COUNTDOWN_OFS:
        rd = {15'h0000, rif.remaining};
      IRQ_STAT_OFS:
        rd = {27'h0000000, s_reg.irq_stat};
      IRQ_MASK_OFS:
        rd = {27'h0000000, s_reg.irq_mask};
      default:
        rd = 32'h00000000;
    endcase
    for (int i = 0; i < NUM_ERR; i++)
    begin
      if (ra == PERR_BASE + 8'(4 * i))
        rd = {15'h0000, s_reg.perr[i]};
      if (ra == BERR_BASE + 8'(4 * i))
        rd = {15'h0000, s_reg.berr[i]};
    end
    for (int p = 0; p < NUM_PSU; p++)
    begin
      if (ra == PSU_BASE + 8'(4 * p))
        rd = {s_reg.psu_hours[p], s_reg.psu_cnt[p]};
    end
    for (int t = 0; t < NUM_TEMP; t++)
    begin
      if (ra == TEMP_BASE + 8'(4 * t))
      begin
        if (s_reg.tseen[t])
          rd = {8'h00, s_reg.tmax[t], s_reg.tmin[t], s_reg.tcur[t]};
        else
          rd = {7'h00, 1'b1, 24'h000000};
      end
    end

    // Address phase capture
    s_next.ph_wr = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      s_next.ph_wr = hwrite && addr_ok;
      s_next.ph_addr = ra;
      s_next.hrdata = (addr_ok && !hwrite) ? rd : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= '0;
      s_reg.hready <= 1'b1;
      s_reg.nch <= NCH_RESET;
      s_reg.delay <= DELAY_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign hrdata      = s_reg.hrdata;
  assign hreadyout   = s_reg.hready;
  assign hresp       = s_reg.hresp;
  assign sel_backup  = s_reg.sel_backup;
  assign chan_backup = s_reg.chan;
  assign irq         = s_reg.irq;

endmodule

// ==== test/ref_gen_pair.sv ====
`timescale 1ns/100ps
module ref_gen_pair
(
  input  wire logic       hclk,
  input  wire logic       pf_req,
  input  wire logic       bf_req,
  input  wire logic [3:0] lag,
  output logic            primary_fault,
  output logic            backup_fault
);
  logic [3:0] cnt;
  initial
  begin
    primary_fault = 1'b0;
    backup_fault  = 1'b0;
    cnt           = 4'h0;
  end
  // Fault pins follow the request after lag cycles
  always @(posedge hclk)
    if ({pf_req, bf_req} == {primary_fault, backup_fault})
      cnt <= 4'h0;
    else if (cnt >= lag)
    begin
      primary_fault <= pf_req;
      backup_fault  <= bf_req;
      cnt           <= 4'h0;
    end
    else
      cnt <= cnt + 4'h1;
endmodule

// ==== test/changeover_monitor.sv ====
`timescale 1ns/100ps
module changeover_monitor
  import changeover_pkg::*;
#(
  parameter int CYCLES_PER_SECOND_P = CYCLES_PER_SECOND
)
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              primary_fault,
  input wire logic              backup_fault,
  input wire logic [1:0]        psu_ok,
  input wire logic [3:0]        temp_fitted,
  input wire logic              temp_strobe,
  input wire logic [3:0][7:0]   temp_data,
  input wire logic              sel_backup,
  input wire logic [NUM_CH-1:0] chan_backup,
  input wire logic              irq
);
  logic       ap_wr_reg;
  logic [7:0] ap_a_reg;
  logic       manual_reg;
  logic       delay_reg;
  logic       manb_reg;
  logic [4:0] mask_reg;
  // Shadow of mode and mask bits from bus writes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ap_wr_reg  <= 1'b0;
      ap_a_reg   <= 8'h00;
      manual_reg <= 1'b0;
      delay_reg  <= 1'b0;
      manb_reg   <= 1'b0;
      mask_reg   <= 5'h00;
    end
    else
    begin
      ap_wr_reg <= hsel && htrans[1] && hready && hwrite && (haddr[31:8] == 24'h000000);
      ap_a_reg  <= haddr[7:0];
      if (ap_wr_reg && ap_a_reg == CTRL_OFS)
      begin
        manual_reg <= hwdata[CTL_MANUAL];
        manb_reg   <= hwdata[CTL_MAN_BACKUP];
        delay_reg  <= hwdata[CTL_REC_DELAY];
      end
      if (ap_wr_reg && ap_a_reg == IRQ_MASK_OFS)
        mask_reg <= hwdata[IRQ_W-1:0];
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence auto_quiet;
    !manual_reg && !delay_reg && $stable({primary_fault, backup_fault});
  endsequence
  sequence pf_onset;
    !manual_reg && $rose(primary_fault) ##1 (primary_fault && !manual_reg)[*3];
  endsequence
  a_chan_agree: assert property (chan_backup == {NUM_CH{sel_backup}})
    else $error("channels disagree with selection");
  a_auto_table: assert property (auto_quiet[*6] |-> sel_backup == primary_fault)
    else $error("auto selection wrong");
  a_fault_switch: assert property (pf_onset |-> sel_backup)
    else $error("no switch to backup");
  a_manual_follow: assert property ((manual_reg && $stable(manb_reg))[*4] |-> sel_backup == manb_reg)
    else $error("manual choice not followed");
  a_delay_hold: assert property (!manual_reg && delay_reg && sel_backup && $fell(primary_fault)
    && !backup_fault |-> sel_backup[*8])
    else $error("recovery did not wait");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_unmapped_zero: assert property (hsel && htrans[1] && hready && !hwrite && haddr == 32'h000000fc
    |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_irq_masked: assert property ((mask_reg == 5'h00)[*2] |-> !irq)
    else $error("irq while fully masked");
  a_irq_change: assert property ($changed(sel_backup) && mask_reg[IRQ_CHANGE] |-> ##[1:2] irq)
    else $error("changeover irq missing");
endmodule
bind redundant_source_changeover changeover_monitor #(.CYCLES_PER_SECOND_P(CYCLES_PER_SECOND_P)) changeover_monitor_i
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .primary_fault, .backup_fault, .psu_ok, .temp_fitted, .temp_strobe, .temp_data, .sel_backup, .chan_backup, .irq
);

// ==== test/redundant_source_changeover_tb.sv ====
`timescale 1ns/100ps
module redundant_source_changeover_tb
  import changeover_pkg::*;
;
  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  wire               hready;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic              primary_fault;
  logic              backup_fault;
  logic              pf_req;
  logic              bf_req;
  logic [3:0]        lag;
  logic [1:0]        psu_ok;
  logic [3:0]        temp_fitted;
  logic              temp_strobe;
  logic [3:0][7:0]   temp_data;
  logic              sel_backup;
  logic [NUM_CH-1:0] chan_backup;
  logic              irq;
  logic [31:0]       q_exp[$];
  logic [31:0]       q_seen[$];
  logic [3:0]        nv[5];
  logic [3:0]        cur;
  logic [1:0]        fl[6];
  logic [31:0]       r;
  event              got;
  int                n_mismatch;
  int                n_tests;
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  redundant_source_changeover #(.CYCLES_PER_SECOND_P(20)) redundant_source_changeover_i
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .primary_fault, .backup_fault, .psu_ok, .temp_fitted, .temp_strobe, .temp_data, .sel_backup, .chan_backup, .irq
  );
  ref_gen_pair ref_gen_pair_i (.hclk, .pf_req, .bf_req, .lag, .primary_fault, .backup_fault);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Compares each noted result with its expectation
  always @(got)
    while (q_exp.size() > 0)
      check(q_seen.pop_front(), q_exp.pop_front());
  task automatic note(input logic [31:0] s, input logic [31:0] e);
    q_exp.push_back(e);
    q_seen.push_back(s);
    -> got;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rv);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rv;
    bus(1'b1, a, d, rv);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] rv;
    bus(1'b0, a, 32'h0, rv);
    note(rv & m, e & m);
  endtask
  task automatic faults(input logic p, input logic b);
    lag    <= 4'($urandom_range(0, 3));
    pf_req <= p;
    bf_req <= b;
    repeat (12) @(posedge hclk);
  endtask
  task automatic strobe(input logic [7:0] v);
    temp_data   <= 32'(v);
    repeat (3) @(posedge hclk);
    temp_strobe <= 1'b1;
    repeat (4) @(posedge hclk);
    temp_strobe <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task automatic finish_test;
    $display("Counts: %0d mismatches in %0d comparisons", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (8000) @(posedge hclk);
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    {hclk, hresetn, hsel, hwrite, pf_req, bf_req, temp_strobe} = 7'h00;
    {haddr, hwdata, htrans, lag, temp_data} = '0;
    hsize       = 3'h2;
    psu_ok      = 2'b11;
    temp_fitted = 4'b0101;
    r           = $urandom(32'h490a);
    nv          = '{4'h1, 4'hc, 4'hd, 4'h0, 4'($urandom_range(1, 12))};
    fl          = '{2'b00, 2'b10, 2'b11, 2'b01, 2'b10, 2'b00};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CTRL_OFS, 32'hffffffff, 32'h0000000c);
    rd(STATUS_OFS, 32'hffffffff, 32'h00000c0c);
    cur = 4'hc;
    foreach (nv[i])
    begin
      wr(CTRL_OFS, 32'(nv[i]));
      if (nv[i] >= 4'h1 && nv[i] <= 4'hc)
        cur = nv[i];
      rd(CTRL_OFS, 32'hffffffff, 32'(cur));
    end
    wr(CTRL_OFS, 32'h0000000c);
    wr(IRQ_MASK_OFS, 32'h00000001);
    foreach (fl[i])
    begin
      faults(fl[i][1], fl[i][0]);
      note(32'(sel_backup), 32'(fl[i][1]));
      note(32'(chan_backup), 32'({NUM_CH{fl[i][1]}}));
      rd(STATUS_OFS, 32'h000001a0, 32'(fl[i][0]) << 8 | 32'(fl[i][1]) << 7 | 32'(fl[i][1]) << 5);
    end
    note(32'(irq), 32'h1);
    rd(IRQ_STAT_OFS, 32'h00000007, 32'h00000007);
    wr(IRQ_STAT_OFS, 32'h0000001f);
    rd(IRQ_STAT_OFS, 32'h0000001f, 32'h00000000);
    note(32'(irq), 32'h0);
    faults(1'b1, 1'b0);
    note(32'(irq), 32'h1);
    wr(IRQ_MASK_OFS, 32'h00000000);
    repeat (2) @(posedge hclk);
    note(32'(irq), 32'h0);
    for (int b = 0; b < 2; b++)
    begin
      wr(CTRL_OFS, 32'h0000001c | 32'(b) << 5);
      faults(b == 0, b == 1);
      note(32'(sel_backup), 32'(b));
      rd(STATUS_OFS, 32'h00000030, 32'h00000010 | 32'(b) << 5);
    end
    wr(CTRL_OFS, 32'h0000000c);
    faults(1'b0, 1'b0);
    wr(DELAY_OFS, 32'h00015180);
    rd(DELAY_OFS, 32'hffffffff, 32'h0001517f);
    repeat (2) @(posedge hclk);
    rd(DELAY_HMS_OFS, 32'hffffffff, 32'h00173b3b);
    wr(DELAY_OFS, 32'h00000003);
    wr(CTRL_OFS, 32'h0000004c);
    faults(1'b1, 1'b0);
    faults(1'b0, 1'b0);
    note(32'(sel_backup), 32'h1);
    rd(STATUS_OFS, 32'h00000200, 32'h00000200);
    bus(1'b0, COUNTDOWN_OFS, 32'h0, r);
    note(32'(r >= 32'h1 && r <= 32'h3), 32'h1);
    repeat (70) @(posedge hclk);
    note(32'(sel_backup), 32'h0);
    rd(STATUS_OFS, 32'h00000200, 32'h00000000);
    strobe(8'h0a);
    wr(CTRL_OFS, 32'h0000040c);
    strobe(8'h05);
    strobe(8'h14);
    rd(TEMP_BASE, 32'hffffffff, 32'h00140514);
    rd(TEMP_BASE + 4, 32'hffffffff, 32'h01000000);
    wr(CTRL_OFS, 32'h0000010c);
    rd(PSU_BASE, 32'hffffffff, 32'h00000000);
    psu_ok <= 2'b10;
    repeat (6) @(posedge hclk);
    psu_ok <= 2'b11;
    repeat (6) @(posedge hclk);
    rd(PSU_BASE, 32'h0000ffff, 32'h00000001);
    rd(IRQ_STAT_OFS, 32'h00000008, 32'h00000008);
    // A new primary fault pushes the newest stamp down one slot
    bus(1'b0, PERR_BASE, 32'h0, r);
    faults(1'b1, 1'b0);
    faults(1'b0, 1'b0);
    rd(PERR_BASE + 4, 32'hffffffff, r);
    rd(32'h000000fc, 32'hffffffff, 32'h00000000);
    rd(32'h00000100, 32'hffffffff, 32'h00000000);
    wr(STATUS_OFS, 32'hffffffff);
    rd(STATUS_OFS, 32'h0000003f, 32'h0000000c);
    repeat (2) @(posedge hclk);
    finish_test();
  end
endmodule
